// [rtl/rpi_pkg.sv]
// Package for the per-port interrupt status block: register offsets, fields
// and the packed carriers shared by the top module.
// Assumes an 8-bit register access port with one-cycle read/write strobes.
package rpi_pkg;

  localparam int unsigned NUM_PORTS = 2;
  localparam int unsigned NUM_LINES = 4;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_PORT_SEL        = 8'h4C;
  localparam logic [7:0] OFS_CAM_RX_STATUS   = 8'h7A;
  localparam logic [7:0] OFS_PORT_IRQ_CTL_LO = 8'hD9;
  localparam logic [7:0] OFS_PORT_IRQ_STS_HI = 8'hDA;
  localparam logic [7:0] OFS_PORT_IRQ_STS_LO = 8'hDB;
  localparam logic [7:0] OFS_FWD_GPIO_STS    = 8'hDC;
  localparam logic [7:0] OFS_FWD_GPIO_IEN    = 8'hDD;
  localparam logic [7:0] OFS_SENSOR_RISE_STS = 8'hDE;
  localparam logic [7:0] OFS_RX_STATUS_ONE   = 8'hE0;
  localparam logic [7:0] OFS_RX_STATUS_TWO   = 8'hE1;
  localparam logic [7:0] OFS_SENSOR_MASK     = 8'hE2;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned BIT_LINE_LEN  = 6;
  localparam int unsigned BIT_LINE_CNT  = 5;
  localparam int unsigned BIT_OVERFLOW  = 4;
  localparam int unsigned BIT_CAM_ERR   = 3;
  localparam int unsigned BIT_PARITY    = 2;
  localparam int unsigned BIT_PORT_OK   = 1;
  localparam int unsigned BIT_LOCK      = 0;
  localparam int unsigned BIT_GPIO_SUM  = 4;
  localparam int unsigned GPIO_EVT_LSB  = 4;
  localparam int unsigned PORT_SEL_LSB  = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Per-port event strobes and live levels from the receive datapath
  typedef struct packed {
    logic       line_len_chg;
    logic       line_cnt_chg;
    logic       overflow;
    logic       cam_err;
    logic       parity_err;
    logic       port_valid;
    logic       lock;
    logic [3:0] fwd_gpio;
    logic [7:0] sensor_sts;
  } rpi_port_in_t;

  // Per-port register state
  typedef struct packed {
    logic [6:0] irq_flags;
    logic [6:0] irq_enable;
    logic       gpio_summary;
    logic [3:0] gpio_event;
    logic [7:0] gpio_ien;
    logic [7:0] sensor_latch;
    logic [7:0] sensor_mask;
    logic [3:0] gpio_prev;
    logic [7:0] sensor_prev;
    logic       valid_prev;
    logic       lock_prev;
  } rpi_port_t;

  typedef struct packed {
    rpi_port_t [NUM_PORTS-1:0] port;
    logic      [NUM_PORTS-1:0] port_sel;
    logic      [7:0]           rdata;
    logic                      rvalid;
    logic                      irq;
  } rpi_state_t;

endpackage

// [rtl/rpi_top.sv]
// Per-receive-port interrupt status, forward GPIO edge events and sensor
// rise latching, reached through an 8-bit register port with port paging.
// Assumes read/write strobes are one-cycle and synchronous to SYS_CLK_IN.
//
// How it works
// - Line length change sets bit 6; read of status two clears it.
// - Line count change sets bit 5; read of status two clears it.
// - Receive buffer overflow sets bit 4; read of status two clears it.
// - Camera receiver error sets bit 3; read of 0x7A clears it.
// - Link parity error sets bit 2; read of status one clears it.
// - Port valid change sets bit 1; read of status one clears it.
// - Lock change sets bit 0; read of status one clears it.
// - GPIO event bits 7:4 latch per line and clear on read.
// - GPIO status bits 3:0 show live line levels, unaffected by reads.
// - Falling edge raises a GPIO event only with its fall enable set.
// - Rising edge raises a GPIO event only with its rise enable set.
// - Masked sensor status rises latch in sensor rise status; read clears.
// - Port select at 0x4C steers writes and read clears to every selected port's copy; reads return the lowest selected port's copy.
// - Status flags drive the interrupt only with their enable bit; GPIO and sensor events drive it unmasked.
// - Pending GPIO events show at high status bit 4; GPIO read clears.
module rpi_top
  import rpi_pkg::*;
(
  // Clock and reset
  input  wire logic                           SYS_CLK_IN,
  input  wire logic                           RST_IN,
  input  wire logic                           CLK_EN_IN,
  // Register port
  input  wire logic                           REG_WR_IN,
  input  wire logic                           REG_RD_IN,
  input  wire logic [7:0]                     REG_ADDR_IN,
  input  wire logic [7:0]                     REG_WDATA_IN,
  output logic      [7:0]                     REG_RDATA_OUT,
  output logic                                REG_RVALID_OUT,
  // Receive port events
  input  wire rpi_pkg::rpi_port_in_t [1:0]    PORT_IN,
  // Interrupt
  output logic                                IRQ_OUT
);
  import rpi_pkg::*;

  rpi_state_t st_reg;
  rpi_state_t st_next;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [7:0] gpio_status(input rpi_port_t p,
                                             input logic [3:0] lvl);
    gpio_status = {p.gpio_event, lvl};
  endfunction

  function automatic logic [3:0] gpio_edges(input logic [3:0] prev,
                                            input logic [3:0] now,
                                            input logic [7:0] ien);
    logic [3:0] e;
    e = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      e[i] = (ien[2*i+1] & prev[i] & ~now[i])
           | (ien[2*i] & ~prev[i] & now[i]);
    end
    gpio_edges = e;
  endfunction

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    logic [6:0] ev;
    logic [6:0] clr;
    logic [3:0] gev;
    logic [7:0] srise;
    logic       sel;
    logic       rd_hit;
    logic       wr_hit;
    logic       any_irq;
    ev      = '0;
    clr     = '0;
    gev     = '0;
    srise   = '0;
    sel     = 1'b0;
    rd_hit  = 1'b0;
    wr_hit  = 1'b0;
    any_irq = 1'b0;
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      sel    = st_reg.port_sel[p];
      rd_hit = REG_RD_IN & sel;
      wr_hit = REG_WR_IN & sel;
      ev = '0;
      ev[BIT_LINE_LEN] = PORT_IN[p].line_len_chg;
      ev[BIT_LINE_CNT] = PORT_IN[p].line_cnt_chg;
      ev[BIT_OVERFLOW] = PORT_IN[p].overflow;
      ev[BIT_CAM_ERR]  = PORT_IN[p].cam_err;
      ev[BIT_PARITY]   = PORT_IN[p].parity_err;
      ev[BIT_PORT_OK]  = PORT_IN[p].port_valid
                         ^ st_reg.port[p].valid_prev;
      ev[BIT_LOCK]     = PORT_IN[p].lock ^ st_reg.port[p].lock_prev;
      clr = '0;
      if (rd_hit && REG_ADDR_IN == OFS_RX_STATUS_TWO) begin
        clr[BIT_LINE_LEN] = 1'b1;
        clr[BIT_LINE_CNT] = 1'b1;
        clr[BIT_OVERFLOW] = 1'b1;
      end
      if (rd_hit && REG_ADDR_IN == OFS_CAM_RX_STATUS) begin
        clr[BIT_CAM_ERR] = 1'b1;
      end
      if (rd_hit && REG_ADDR_IN == OFS_RX_STATUS_ONE) begin
        clr[BIT_PARITY]  = 1'b1;
        clr[BIT_PORT_OK] = 1'b1;
        clr[BIT_LOCK]    = 1'b1;
      end
      // Set beats clear so an event landing on the read is kept
      st_next.port[p].irq_flags = (st_reg.port[p].irq_flags & ~clr)
                                  | ev;
      st_next.port[p].valid_prev = PORT_IN[p].port_valid;
      st_next.port[p].lock_prev  = PORT_IN[p].lock;

      gev = gpio_edges(st_reg.port[p].gpio_prev, PORT_IN[p].fwd_gpio,
                       st_reg.port[p].gpio_ien);
      st_next.port[p].gpio_prev = PORT_IN[p].fwd_gpio;
      if (rd_hit && REG_ADDR_IN == OFS_FWD_GPIO_STS) begin
        st_next.port[p].gpio_event   = gev;
        st_next.port[p].gpio_summary = |gev;
      end else begin
        st_next.port[p].gpio_event   = st_reg.port[p].gpio_event
                                       | gev;
        st_next.port[p].gpio_summary = st_reg.port[p].gpio_summary
                                       | (|gev);
      end

      srise = st_reg.port[p].sensor_mask & PORT_IN[p].sensor_sts
              & ~st_reg.port[p].sensor_prev;
      st_next.port[p].sensor_prev = PORT_IN[p].sensor_sts;
      if (rd_hit && REG_ADDR_IN == OFS_SENSOR_RISE_STS) begin
        st_next.port[p].sensor_latch = srise;
      end else begin
        st_next.port[p].sensor_latch = st_reg.port[p].sensor_latch
                                       | srise;
      end

      if (wr_hit) begin
        unique case (REG_ADDR_IN)
          OFS_PORT_IRQ_CTL_LO: st_next.port[p].irq_enable = REG_WDATA_IN[6:0];
          OFS_FWD_GPIO_IEN:    st_next.port[p].gpio_ien   = REG_WDATA_IN;
          OFS_SENSOR_MASK:     st_next.port[p].sensor_mask = REG_WDATA_IN;
          default: ;
        endcase
      end
      any_irq = any_irq
              | (|(st_reg.port[p].irq_flags & st_reg.port[p].irq_enable))
              | st_reg.port[p].gpio_summary
              | (|st_reg.port[p].sensor_latch);
    end

    if (REG_WR_IN && REG_ADDR_IN == OFS_PORT_SEL) begin
      st_next.port_sel = REG_WDATA_IN[PORT_SEL_LSB +: NUM_PORTS];
    end

    // Reads return the lowest selected port's copy
    if (REG_RD_IN) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = RST_BYTE;
      for (int p = NUM_PORTS - 1; p >= 0; p--) begin
        if (st_reg.port_sel[p]) begin
          unique case (REG_ADDR_IN)
            OFS_PORT_SEL:
              st_next.rdata = {6'h00, st_reg.port_sel};
            OFS_PORT_IRQ_CTL_LO:
              st_next.rdata = {1'b0, st_reg.port[p].irq_enable};
            OFS_PORT_IRQ_STS_HI:
              st_next.rdata = {3'h0, st_reg.port[p].gpio_summary, 4'h0};
            OFS_PORT_IRQ_STS_LO:
              st_next.rdata = {1'b0, st_reg.port[p].irq_flags};
            OFS_FWD_GPIO_STS:
              st_next.rdata = gpio_status(st_reg.port[p],
                                          PORT_IN[p].fwd_gpio);
            OFS_FWD_GPIO_IEN:
              st_next.rdata = st_reg.port[p].gpio_ien;
            OFS_SENSOR_RISE_STS:
              st_next.rdata = st_reg.port[p].sensor_latch;
            OFS_SENSOR_MASK:
              st_next.rdata = st_reg.port[p].sensor_mask;
            default:
              st_next.rdata = RST_BYTE;
          endcase
        end
      end
      if (REG_ADDR_IN == OFS_PORT_SEL) begin
        st_next.rdata = {6'h00, st_reg.port_sel};
      end
    end
    st_next.irq = any_irq;
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_reg <= '0;
    end else if (CLK_EN_IN) begin
      st_reg <= st_next;
    end
  end

  assign REG_RDATA_OUT  = st_reg.rdata;
  assign REG_RVALID_OUT = st_reg.rvalid;
  assign IRQ_OUT        = st_reg.irq;

endmodule

// [bench/rpi_properties.sv]
// Concurrent checks on the ports of the port interrupt status block.
// Assumes CLK_EN_IN qualifies every strobe; port 0 is read back when selected.
module rpi_properties
  import rpi_pkg::*;
(
  // Clock and reset
  input  wire logic                        SYS_CLK_IN,
  input  wire logic                        RST_IN,
  input  wire logic                        CLK_EN_IN,
  // Register port
  input  wire logic                        REG_WR_IN,
  input  wire logic                        REG_RD_IN,
  input  wire logic [7:0]                  REG_ADDR_IN,
  input  wire logic [7:0]                  REG_WDATA_IN,
  input  wire logic [7:0]                  REG_RDATA_OUT,
  input  wire logic                        REG_RVALID_OUT,
  // Events and interrupt
  input  wire rpi_pkg::rpi_port_in_t [1:0] PORT_IN,
  input  wire logic                        IRQ_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  logic       rd;
  logic       wr;
  logic [1:0] sel_reg;
  logic [7:0] ien_reg;
  assign rd = REG_RD_IN && CLK_EN_IN;
  assign wr = REG_WR_IN && CLK_EN_IN;
  // ------------------------------------------------------------------
  // Shadow of page select and port 0 edge enables, from observed writes
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sel_reg <= 2'h0;
      ien_reg <= 8'h00;
    end else begin
      if (wr && REG_ADDR_IN == OFS_PORT_SEL)
        sel_reg <= REG_WDATA_IN[1:0];
      if (wr && REG_ADDR_IN == OFS_FWD_GPIO_IEN && sel_reg[0])
        ien_reg <= REG_WDATA_IN;
    end
  end
  sequence s_rd(logic [7:0] a);
    rd && REG_ADDR_IN == a && sel_reg[0];
  endsequence
  // No fresh port 0 event that a clearing read would have to keep
  sequence s_quiet;
    !PORT_IN[0].parity_err && $stable(PORT_IN[0].port_valid)
      && $stable(PORT_IN[0].lock);
  endsequence
  a_read_answered: assert property (rd |=> REG_RVALID_OUT)
    else $error("read strobe got no answer");
  a_answer_source: assert property (REG_RVALID_OUT |-> $past(rd))
    else $error("answer without a read");
  a_unmapped_zero: assert property (rd && REG_ADDR_IN < 8'h4C
    |=> REG_RDATA_OUT == 8'h00) else $error("unmapped read not zero");
  a_unselected_zero: assert property (rd && sel_reg == 2'h0
    && REG_ADDR_IN inside {[8'hD9:8'hE2]} |=> REG_RDATA_OUT == 8'h00)
    else $error("port read with no port selected not zero");
  a_gpio_live: assert property (s_rd(OFS_FWD_GPIO_STS)
    |=> REG_RDATA_OUT[3:0] == $past(PORT_IN[0].fwd_gpio))
    else $error("live gpio levels wrong");
  a_enable_back: assert property (s_rd(OFS_FWD_GPIO_IEN)
    |=> REG_RDATA_OUT == $past(ien_reg)) else $error("edge enables wrong");
  a_status_clear: assert property (s_rd(OFS_RX_STATUS_ONE) ##0 s_quiet
    ##1 s_quiet ##1 s_rd(OFS_PORT_IRQ_STS_LO) ##0 s_quiet
    |=> REG_RDATA_OUT[2:0] == 3'h0)
    else $error("low flags survived clearing read");
  a_event_kept: assert property (s_rd(OFS_RX_STATUS_ONE)
    ##0 PORT_IN[0].parity_err ##2 s_rd(OFS_PORT_IRQ_STS_LO)
    |=> REG_RDATA_OUT[2]) else $error("event lost in clearing read");
endmodule

bind rpi_top rpi_properties chk_u (.SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN),
  .CLK_EN_IN(CLK_EN_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT),
  .PORT_IN(PORT_IN), .IRQ_OUT(IRQ_OUT));

// [bench/rpi_top_bench.sv]
// Register-level bench for the port interrupt status block.
// Assumes one-cycle strobes and an answer one cycle after each read.
module rpi_top_bench
  import rpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               en = 1'b1;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic [7:0]         addr = 8'h00;
  logic [7:0]         wdata = 8'h00;
  logic [7:0]         rdata;
  logic               rvalid;
  logic               irq;
  rpi_port_in_t [1:0] p = '0;
  int                 n_fail = 0;
  int                 check_count = 0;
  always #4 clk = ~clk;
  rpi_top dut_u (.SYS_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(en),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
    .REG_RVALID_OUT(rvalid), .PORT_IN(p), .IRQ_OUT(irq));
  // ------------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1; addr = a; wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // Optional parity event rides in the same cycle as the read strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp,
                        input logic ev = 1'b0);
    int n;
    @(negedge clk);
    rd = 1'b1; addr = a; p[0].parity_err = ev;
    @(negedge clk);
    rd = 1'b0; p[0].parity_err = 1'b0;
    for (n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge clk);
    if (n == 4) begin
      n_fail++;
      $display("BAD %0t no read answer", $time);
      complete_run();
    end
    chk(rdata, exp);
  endtask
  // Event pulses, high to low: length, count, overflow, camera, parity
  task automatic pulse(input int k, input logic [4:0] ev);
    @(negedge clk);
    p[k][18:14] = ev;
    @(negedge clk);
    p[k][18:14] = 5'h00;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    rd_reg(OFS_PORT_IRQ_STS_LO, 8'h00);
    wr_reg(OFS_PORT_SEL, 8'h01);
    rd_reg(8'h10, 8'h00);
    rd_reg(OFS_FWD_GPIO_IEN, 8'h00);
    rd_reg(OFS_SENSOR_RISE_STS, 8'h00);
    pulse(0, 5'h1F);
    @(negedge clk) p[0][13:12] = 2'h3;
    rd_reg(OFS_PORT_IRQ_STS_LO, 8'h7F);
    rd_reg(OFS_RX_STATUS_TWO, 8'h00);
    rd_reg(OFS_PORT_IRQ_STS_LO, 8'h0F);
    rd_reg(OFS_CAM_RX_STATUS, 8'h00);
    rd_reg(OFS_PORT_IRQ_STS_LO, 8'h07);
    rd_reg(OFS_RX_STATUS_ONE, 8'h00, 1'b1);
    rd_reg(OFS_PORT_IRQ_STS_LO, 8'h04);
    rd_reg(OFS_RX_STATUS_ONE, 8'h00);
    rd_reg(OFS_PORT_IRQ_STS_LO, 8'h00);
    wr_reg(OFS_PORT_IRQ_CTL_LO, 8'h40);
    pulse(0, 5'h08);
    repeat (3) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    pulse(0, 5'h10);
    repeat (3) @(negedge clk);
    chk({7'h00, irq}, 8'h01);
    rd_reg(OFS_RX_STATUS_TWO, 8'h00);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    wr_reg(OFS_PORT_SEL, 8'h02);
    pulse(1, 5'h04);
    rd_reg(OFS_PORT_IRQ_STS_LO, 8'h10);
    wr_reg(OFS_PORT_SEL, 8'h01);
    rd_reg(OFS_PORT_IRQ_STS_LO, 8'h00);
    wr_reg(OFS_FWD_GPIO_IEN, 8'h55);
    rd_reg(OFS_FWD_GPIO_IEN, 8'h55);
    @(negedge clk) p[0].fwd_gpio = 4'hF;
    rd_reg(OFS_PORT_IRQ_STS_HI, 8'h10);
    chk({7'h00, irq}, 8'h01);
    rd_reg(OFS_FWD_GPIO_STS, 8'hFF);
    rd_reg(OFS_PORT_IRQ_STS_HI, 8'h00);
    rd_reg(OFS_FWD_GPIO_STS, 8'h0F);
    @(negedge clk) p[0].fwd_gpio = 4'h0;
    rd_reg(OFS_FWD_GPIO_STS, 8'h00);
    wr_reg(OFS_FWD_GPIO_IEN, 8'hAA);
    @(negedge clk) p[0].fwd_gpio = 4'hF;
    rd_reg(OFS_FWD_GPIO_STS, 8'h0F);
    @(negedge clk) p[0].fwd_gpio = 4'h0;
    rd_reg(OFS_FWD_GPIO_STS, 8'hF0);
    wr_reg(OFS_SENSOR_MASK, 8'h0F);
    @(negedge clk) p[0].sensor_sts = 8'hFF;
    rd_reg(OFS_SENSOR_RISE_STS, 8'h0F);
    rd_reg(OFS_SENSOR_RISE_STS, 8'h00);
    // Frozen clock enable: an event pulse in that time is not latched
    @(negedge clk) en = 1'b0;
    pulse(0, 5'h10);
    @(negedge clk) en = 1'b1;
    rd_reg(OFS_PORT_IRQ_STS_LO, 8'h00);
    complete_run();
  end
endmodule
